// ==== logic/rccs_params.svh ====
// register offsets, field positions and reset values of the reset-cause and clock-select block
`ifndef RCCS_PARAMS_SVH
`define RCCS_PARAMS_SVH
`define RCCS_ADDR_CAUSE 32'h40023874
`define RCCS_ADDR_CTRL 32'h40023800
`define RCCS_ADDR_BKUP 32'h40023870
`define RCCS_ADDR_CFG 32'h40023808
`define RCCS_ADDR_OPT 32'h40023810
`define RCCS_ADDR_INTST 32'h40023814
`define RCCS_ADDR_INTMSK 32'h40023818
`define RCCS_BIT_RC_EN 0
`define RCCS_BIT_RC_STB 1
`define RCCS_BIT_CLR 24
`define RCCS_BIT_FLAG_LO 25
`define RCCS_NUM_CAUSES 7
`define RCCS_BIT_FAST_BYP 0
`define RCCS_BIT_PLL_SRC 1
`define RCCS_BIT_SLOW_BYP 0
`define RCCS_BIT_OUTA_LO 0
`define RCCS_BIT_OUTB_LO 2
`define RCCS_BIT_BOR_LO 0
`define RCCS_BOR_RESET 2'h3
`define RCCS_RC_SETTLE 4'hF
`define RCCS_RESP_OKAY 2'h0
`define RCCS_RESP_SLVERR 2'h2
`endif

// ==== logic/rccs_pkg.sv ====
// types shared by the reset-cause and clock-select block
package rccs_pkg;
  typedef enum logic [1:0] {
    RCCS_SRC_A = 2'h0,
    RCCS_SRC_B = 2'h1,
    RCCS_SRC_C = 2'h2,
    RCCS_SRC_D = 2'h3
  } rccs_sel_t;
  typedef enum logic [2:0] {
    RCCS_W_IDLE = 3'h1,
    RCCS_W_HAVE = 3'h2,
    RCCS_W_RESP = 3'h4
  } rccs_wstate_t;
endpackage

// ==== logic/rccs_top.sv ====
// reset-cause record and clock-source selection with an AXI4-Lite register slave
// Summary of operation
// - cause status register sits at 0x40023874 for software to read
// - cause flags stick; system reset keeps them, only power-on reset or the clear bit clears them
// - writing one to bit 24 clears all cause flags
// - bits 31..25: low-power, window wd, free wd, software, power-on, pin, brownout
// - pll reference selectable between fast crystal and internal fast rc
// - fast crystal bypass bit takes external clock directly on input pin
// - slow crystal bypass bit takes external clock on 32 kHz input
// - output a source: 00 fast rc, 01 slow crystal, 10 fast crystal, 11 pll p
// - output b has its own selector; code 00 routes system clock
// - supply monitor enable pin keeps power-on/down detection active
// - brownout threshold option defaults to 11, meaning brownout reset off
//
// The AXI4-Lite register port was left to the implementer.
`include "rccs_params.svh"
module rccs_top import rccs_pkg::*; (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_por_rst,
  // reset events, one per cause, asynchronous levels
  input wire logic [`RCCS_NUM_CAUSES-1:0] i_cause_events,
  // oscillator status and supply pin
  input wire logic i_slow_rc_ready,
  input wire logic i_supply_monitor_enable_pin,
  // axi4-lite write address
  input wire logic [31:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  // axi4-lite write data
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // axi4-lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [31:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // clock control, brownout option and supply monitor outputs
  output logic o_slow_rc_enable,
  output logic o_fast_crystal_bypass,
  output logic o_slow_crystal_bypass,
  output logic o_pll_ref_is_rc,
  output logic [1:0] o_clock_output_a_source,
  output logic [1:0] o_clock_output_b_source,
  output logic [1:0] o_brownout_threshold_option,
  output logic o_supply_monitor_active,
  // interrupt
  output logic o_irq
);
  logic [`RCCS_NUM_CAUSES-1:0] ev_s1_q, ev_s2_q, ev_s3_q;
  logic rdy_s1_q, rdy_s2_q, pdr_s1_q, pdr_s2_q;
  logic [`RCCS_NUM_CAUSES-1:0] cause_flags_q;
  logic [3:0] settle_q;
  logic slow_rc_stable_q;
  logic [`RCCS_NUM_CAUSES:0] int_status_q, int_mask_q;
  rccs_wstate_t wstate_q;
  logic aw_have_q, w_have_q;
  logic [31:0] awaddr_q, wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire, wr_hit, cause_clear;
  logic [`RCCS_NUM_CAUSES-1:0] ev_rise;
  logic stable_rise;
  logic [31:0] rd_d;
  logic rd_hit;

  // two-flop synchronisers; the third stage only serves edge detection
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ev_s1_q <= '0;
      ev_s2_q <= '0;
      ev_s3_q <= '0;
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
      pdr_s1_q <= 1'b0;
      pdr_s2_q <= 1'b0;
    end else begin
      ev_s1_q <= i_cause_events;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
      rdy_s1_q <= i_slow_rc_ready;
      rdy_s2_q <= rdy_s1_q;
      pdr_s1_q <= i_supply_monitor_enable_pin;
      pdr_s2_q <= pdr_s1_q;
    end
  end
  assign ev_rise = ev_s2_q & ~ev_s3_q;

  // write channel: address and data may arrive in either order
  assign wr_fire = (wstate_q == RCCS_W_HAVE);
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wstate_q <= RCCS_W_IDLE;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `RCCS_RESP_OKAY;
    end else begin
      unique case (wstate_q)
        RCCS_W_IDLE: begin
          if (i_awvalid && o_awready) begin
            awaddr_q <= i_awaddr;
            aw_have_q <= 1'b1;
            o_awready <= 1'b0;
          end
          if (i_wvalid && o_wready) begin
            wdata_q <= i_wdata;
            wstrb_q <= i_wstrb;
            w_have_q <= 1'b1;
            o_wready <= 1'b0;
          end
          if ((aw_have_q || (i_awvalid && o_awready)) && (w_have_q || (i_wvalid && o_wready))) begin
            wstate_q <= RCCS_W_HAVE;
          end
        end
        RCCS_W_HAVE: begin
          o_bvalid <= 1'b1;
          o_bresp <= wr_hit ? `RCCS_RESP_OKAY : `RCCS_RESP_SLVERR;
          wstate_q <= RCCS_W_RESP;
        end
        RCCS_W_RESP: begin
          if (i_bready) begin
            o_bvalid <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            wstate_q <= RCCS_W_IDLE;
          end
        end
      endcase
    end
  end

  always_comb begin
    wr_hit = 1'b0;
    unique case (awaddr_q)
      `RCCS_ADDR_CAUSE, `RCCS_ADDR_CTRL, `RCCS_ADDR_BKUP, `RCCS_ADDR_CFG,
      `RCCS_ADDR_OPT, `RCCS_ADDR_INTST, `RCCS_ADDR_INTMSK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  assign cause_clear = wr_fire && (awaddr_q == `RCCS_ADDR_CAUSE) && wstrb_q[3]
    && wdata_q[`RCCS_BIT_CLR];

  // sticky flags, only power-on reset or the clear bit wipes them; a new event beats the clear
  always_ff @(posedge i_clock or posedge i_por_rst) begin
    if (i_por_rst) begin
      cause_flags_q <= '0;
    end else begin
      cause_flags_q <= (cause_clear ? '0 : cause_flags_q) | ev_s2_q;
    end
  end

  // slow rc enable and settle count for the stable flag
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_slow_rc_enable <= 1'b0;
      settle_q <= '0;
      slow_rc_stable_q <= 1'b0;
    end else begin
      if (wr_fire && awaddr_q == `RCCS_ADDR_CAUSE && wstrb_q[0]) begin
        o_slow_rc_enable <= wdata_q[`RCCS_BIT_RC_EN];
      end
      if (!o_slow_rc_enable || !rdy_s2_q) begin
        settle_q <= '0;
        slow_rc_stable_q <= 1'b0;
      end else if (settle_q != `RCCS_RC_SETTLE) begin
        settle_q <= settle_q + 4'h1;
      end else begin
        slow_rc_stable_q <= 1'b1;
      end
    end
  end
  assign stable_rise = o_slow_rc_enable && rdy_s2_q && settle_q == `RCCS_RC_SETTLE
    && !slow_rc_stable_q;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_fast_crystal_bypass <= 1'b0;
      o_pll_ref_is_rc <= 1'b1;
      o_slow_crystal_bypass <= 1'b0;
      o_clock_output_a_source <= RCCS_SRC_A;
      o_clock_output_b_source <= RCCS_SRC_A;
      o_brownout_threshold_option <= `RCCS_BOR_RESET;
    end else if (wr_fire && wstrb_q[0]) begin
      unique case (awaddr_q)
        `RCCS_ADDR_CTRL: begin
          o_fast_crystal_bypass <= wdata_q[`RCCS_BIT_FAST_BYP];
          o_pll_ref_is_rc <= wdata_q[`RCCS_BIT_PLL_SRC];
        end
        `RCCS_ADDR_BKUP: o_slow_crystal_bypass <= wdata_q[`RCCS_BIT_SLOW_BYP];
        `RCCS_ADDR_CFG: begin
          o_clock_output_a_source <= wdata_q[`RCCS_BIT_OUTA_LO +: 2];
          o_clock_output_b_source <= wdata_q[`RCCS_BIT_OUTB_LO +: 2];
        end
        `RCCS_ADDR_OPT: o_brownout_threshold_option <= wdata_q[`RCCS_BIT_BOR_LO +: 2];
        default: ;
      endcase
    end
  end

  // supply monitor stays on while the pin is high
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_supply_monitor_active <= 1'b0;
    end else begin
      o_supply_monitor_active <= pdr_s2_q;
    end
  end

  // interrupt status: one bit per cause plus slow rc stable; write one to clear, set wins
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      int_status_q <= '0;
      int_mask_q <= '0;
      o_irq <= 1'b0;
    end else begin
      if (wr_fire && awaddr_q == `RCCS_ADDR_INTST && wstrb_q[0]) begin
        int_status_q <= (int_status_q & ~wdata_q[`RCCS_NUM_CAUSES:0])
          | {stable_rise, ev_rise};
      end else begin
        int_status_q <= int_status_q | {stable_rise, ev_rise};
      end
      if (wr_fire && awaddr_q == `RCCS_ADDR_INTMSK && wstrb_q[0]) begin
        int_mask_q <= wdata_q[`RCCS_NUM_CAUSES:0];
      end
      o_irq <= |(int_status_q & int_mask_q);
    end
  end

  always_comb begin
    rd_d = '0;
    rd_hit = 1'b1;
    unique case (i_araddr)
      `RCCS_ADDR_CAUSE: begin
        rd_d[`RCCS_BIT_FLAG_LO +: `RCCS_NUM_CAUSES] = cause_flags_q;
        rd_d[`RCCS_BIT_RC_STB] = slow_rc_stable_q;
        rd_d[`RCCS_BIT_RC_EN] = o_slow_rc_enable;
      end
      `RCCS_ADDR_CTRL: begin
        rd_d[`RCCS_BIT_FAST_BYP] = o_fast_crystal_bypass;
        rd_d[`RCCS_BIT_PLL_SRC] = o_pll_ref_is_rc;
      end
      `RCCS_ADDR_BKUP: rd_d[`RCCS_BIT_SLOW_BYP] = o_slow_crystal_bypass;
      `RCCS_ADDR_CFG: begin
        rd_d[`RCCS_BIT_OUTA_LO +: 2] = o_clock_output_a_source;
        rd_d[`RCCS_BIT_OUTB_LO +: 2] = o_clock_output_b_source;
      end
      `RCCS_ADDR_OPT: rd_d[`RCCS_BIT_BOR_LO +: 2] = o_brownout_threshold_option;
      `RCCS_ADDR_INTST: rd_d[`RCCS_NUM_CAUSES:0] = int_status_q;
      `RCCS_ADDR_INTMSK: rd_d[`RCCS_NUM_CAUSES:0] = int_mask_q;
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= `RCCS_RESP_OKAY;
    end else if (o_rvalid) begin
      if (i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end else if (i_arvalid) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rdata <= rd_d;
      o_rresp <= rd_hit ? `RCCS_RESP_OKAY : `RCCS_RESP_SLVERR;
    end
  end

  // a flag once set stays unless cleared or power-on reset
  property p_flags_sticky;
    @(posedge i_clock) disable iff (i_por_rst)
      (|cause_flags_q) && !cause_clear |=> (cause_flags_q & $past(cause_flags_q))
        == $past(cause_flags_q);
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) else $error("cause flag lost");

  // clear empties flags unless a new event arrives
  property p_clear;
    @(posedge i_clock) disable iff (i_por_rst)
      cause_clear && ev_s2_q == '0 |=> cause_flags_q == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not empty flags");

  // each cause lands in its own flag one cycle after the synchroniser
  property p_event_flag;
    @(posedge i_clock) disable iff (i_por_rst || i_sys_rst)
      ev_s2_q != '0 |=> (cause_flags_q & $past(ev_s2_q)) == $past(ev_s2_q);
  endproperty
  a_event_flag: assert property (p_event_flag) else $error("event not recorded");

  // stable only while enabled; the flag trails a disable by one cycle
  property p_stable;
    @(posedge i_clock) disable iff (i_sys_rst)
      slow_rc_stable_q |-> $past(o_slow_rc_enable) && $past(rdy_s2_q);
  endproperty
  a_stable: assert property (p_stable) else $error("stable without enable");

  // threshold option leaves reset at 11
  property p_bor_reset;
    @(posedge i_clock) disable iff (i_sys_rst)
      $rose(!i_sys_rst) |-> o_brownout_threshold_option == `RCCS_BOR_RESET;
  endproperty
  a_bor_reset: assert property (p_bor_reset) else $error("brownout default wrong");

  // monitor follows pin within three cycles
  property p_monitor;
    @(posedge i_clock) disable iff (i_sys_rst)
      i_supply_monitor_enable_pin [*3] |-> ##1 o_supply_monitor_active;
  endproperty
  a_monitor: assert property (p_monitor) else $error("monitor not active");

  property p_sel_write;
    @(posedge i_clock) disable iff (i_sys_rst)
      wr_fire && wstrb_q[0] && awaddr_q == `RCCS_ADDR_CFG
        |=> o_clock_output_a_source == $past(wdata_q[`RCCS_BIT_OUTA_LO +: 2]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("source select not written");

  // cause register read returns flags in 31..25
  property p_read_cause;
    @(posedge i_clock) disable iff (i_sys_rst)
      o_arready && i_arvalid && i_araddr == `RCCS_ADDR_CAUSE
        |=> o_rvalid && o_rdata[31:25] == $past(cause_flags_q);
  endproperty
  a_read_cause: assert property (p_read_cause) else $error("cause read wrong");
endmodule

// ==== verification/rccs_top_test.sv ====
// self-checking register-level bench for the reset-cause and clock-select block
`include "rccs_params.svh"
module rccs_top_test import rccs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock, i_sys_rst, i_por_rst, i_slow_rc_ready, i_supply_monitor_enable_pin;
  logic [6:0] i_cause_events;
  logic [31:0] i_awaddr, i_wdata, i_araddr, o_rdata, flags_exp, rv;
  logic [3:0] i_wstrb;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [1:0] o_bresp, o_rresp, rs;
  logic o_slow_rc_enable, o_fast_crystal_bypass, o_slow_crystal_bypass;
  logic o_pll_ref_is_rc, o_supply_monitor_active;
  logic [1:0] o_clock_output_a_source, o_clock_output_b_source, o_brownout_threshold_option;
  int mismatches;
  int checks_done;

  rccs_top uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_por_rst(i_por_rst),
    .i_cause_events(i_cause_events), .i_slow_rc_ready(i_slow_rc_ready),
    .i_supply_monitor_enable_pin(i_supply_monitor_enable_pin),
    .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
    .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
    .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
    .o_slow_rc_enable(o_slow_rc_enable), .o_fast_crystal_bypass(o_fast_crystal_bypass),
    .o_slow_crystal_bypass(o_slow_crystal_bypass), .o_pll_ref_is_rc(o_pll_ref_is_rc),
    .o_clock_output_a_source(o_clock_output_a_source),
    .o_clock_output_b_source(o_clock_output_b_source),
    .o_brownout_threshold_option(o_brownout_threshold_option),
    .o_supply_monitor_active(o_supply_monitor_active), .o_irq(o_irq));

  initial begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    mismatches++;
    $display("[FAIL] %0t bus handshake timed out", $time);
    test_done();
  endtask

  // values are looked at on the falling edge, so they are exactly what the next rise samples
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    @(posedge i_clock);
    i_awaddr <= a;
    i_awvalid <= 1'b1;
    i_wdata <= d;
    i_wstrb <= s;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(negedge i_clock);
      aw_hs = i_awvalid & o_awready;
      w_hs = i_wvalid & o_wready;
      b_hs = o_bvalid;
      r = o_bresp;
      @(posedge i_clock);
      if (aw_hs === 1'b1) i_awvalid <= 1'b0;
      if (w_hs === 1'b1) i_wvalid <= 1'b0;
      if (b_hs === 1'b1) begin
        i_bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    @(posedge i_clock);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(negedge i_clock);
      ar_hs = i_arvalid & o_arready;
      r_hs = o_rvalid;
      d = o_rdata;
      r = o_rresp;
      @(posedge i_clock);
      if (ar_hs === 1'b1) i_arvalid <= 1'b0;
      if (r_hs === 1'b1) begin
        i_rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m);
    rd(a, rv, rs);
    chk({rv & m}, exp);
  endtask

  task automatic fire(input int i);
    @(posedge i_clock);
    i_cause_events <= 7'(1 << i);
    repeat (4) @(posedge i_clock);
    i_cause_events <= 7'h00;
    repeat (4) @(posedge i_clock);
  endtask

  task automatic pulse_sys();
    @(posedge i_clock);
    i_sys_rst <= 1'b1;
    @(posedge i_clock);
    i_sys_rst <= 1'b0;
  endtask

  initial begin
    {i_sys_rst, i_por_rst} = 2'h3;
    {i_slow_rc_ready, i_supply_monitor_enable_pin, i_cause_events} = 9'h000;
    {i_awaddr, i_wdata, i_araddr, i_wstrb} = 100'h0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    mismatches = 0;
    checks_done = 0;
    flags_exp = 32'h00000000;
    repeat (3) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    i_por_rst <= 1'b0;
    chk(32'(o_pll_ref_is_rc), 32'h1);
    chk(32'(o_brownout_threshold_option), 32'h3);
    rdchk(`RCCS_ADDR_OPT, 32'h3, 32'hFFFFFFFF);
    rdchk(`RCCS_ADDR_CAUSE, 32'h0, 32'hFFFFFFFF);
    // slow rc enable, then stable once it has settled
    i_slow_rc_ready <= 1'b1;
    wr(`RCCS_ADDR_CAUSE, 32'h00000001, 4'h1, rs);
    chk(32'(o_slow_rc_enable), 32'h1);
    repeat (24) @(posedge i_clock);
    rdchk(`RCCS_ADDR_CAUSE, 32'h3, 32'hFFFFFFFF);
    rdchk(`RCCS_ADDR_INTST, 32'h80, 32'hFFFFFFFF);
    for (int i = 0; i < 7; i++) begin
      fire(i);
      flags_exp[25+i] = 1'b1;
      rdchk(`RCCS_ADDR_CAUSE, flags_exp | 32'h3, 32'hFFFFFFFF);
    end
    rdchk(`RCCS_ADDR_INTST, 32'hFF, 32'hFFFFFFFF);
    // flags are read-only: a lane-3 write without the clear bit changes nothing
    wr(`RCCS_ADDR_CAUSE, 32'h00000000, 4'h8, rs);
    rdchk(`RCCS_ADDR_CAUSE, flags_exp | 32'h3, 32'hFFFFFFFF);
    pulse_sys();
    rdchk(`RCCS_ADDR_CAUSE, flags_exp, 32'hFFFFFFFC);
    chk(32'(o_pll_ref_is_rc), 32'h1);
    wr(`RCCS_ADDR_CAUSE, 32'h01000000, 4'h8, rs);
    rdchk(`RCCS_ADDR_CAUSE, 32'h0, 32'hFFFFFFFC);
    fire(2);
    rdchk(`RCCS_ADDR_CAUSE, 32'h08000000, 32'hFFFFFFFC);
    @(posedge i_clock);
    i_por_rst <= 1'b1;
    @(posedge i_clock);
    i_por_rst <= 1'b0;
    rdchk(`RCCS_ADDR_CAUSE, 32'h0, 32'hFFFFFFFC);
    // pin mode belongs to the port block; software here only sets the sources and the brownout threshold option
    for (int k = 0; k < 4; k++) begin
      wr(`RCCS_ADDR_CFG, 32'(k) | 32'((3 - k) << 2), 4'h1, rs);
      chk(32'(o_clock_output_a_source), 32'(k));
      chk(32'(o_clock_output_b_source), 32'(3 - k));
      wr(`RCCS_ADDR_OPT, 32'(k), 4'h1, rs);
      chk(32'(o_brownout_threshold_option), 32'(k));
    end
    rdchk(`RCCS_ADDR_CFG, 32'h3, 32'hFFFFFFFF);
    wr(`RCCS_ADDR_CTRL, 32'h1, 4'h1, rs);
    chk({30'h0, o_fast_crystal_bypass, o_pll_ref_is_rc}, 32'h2);
    rdchk(`RCCS_ADDR_CTRL, 32'h1, 32'hFFFFFFFF);
    chk(32'(rs), 32'(`RCCS_RESP_OKAY));
    wr(`RCCS_ADDR_CTRL, 32'h2, 4'h1, rs);
    chk({30'h0, o_fast_crystal_bypass, o_pll_ref_is_rc}, 32'h1);
    wr(`RCCS_ADDR_BKUP, 32'h1, 4'h1, rs);
    chk(32'(o_slow_crystal_bypass), 32'h1);
    chk(32'(rs), 32'(`RCCS_RESP_OKAY));
    // unmapped place is refused and leaves the selectors alone
    wr(32'h40023900, 32'hFFFFFFFF, 4'hF, rs);
    chk(32'(rs), 32'(`RCCS_RESP_SLVERR));
    rd(32'h40023904, rv, rs);
    chk(32'(rs), 32'(`RCCS_RESP_SLVERR));
    chk(32'(o_clock_output_a_source), 32'h3);
    i_supply_monitor_enable_pin <= 1'b1;
    repeat (6) @(posedge i_clock);
    chk(32'(o_supply_monitor_active), 32'h1);
    i_supply_monitor_enable_pin <= 1'b0;
    repeat (6) @(posedge i_clock);
    chk(32'(o_supply_monitor_active), 32'h0);
    // interrupt: raise, masked, unmasked, cleared
    wr(`RCCS_ADDR_INTMSK, 32'h0, 4'h1, rs);
    wr(`RCCS_ADDR_INTST, 32'hFF, 4'h1, rs);
    rdchk(`RCCS_ADDR_INTST, 32'h0, 32'hFFFFFFFF);
    fire(3);
    rdchk(`RCCS_ADDR_INTST, 32'h8, 32'hFFFFFFFF);
    chk(32'(o_irq), 32'h0);
    wr(`RCCS_ADDR_INTMSK, 32'h8, 4'h1, rs);
    rdchk(`RCCS_ADDR_INTMSK, 32'h8, 32'hFFFFFFFF);
    repeat (2) @(posedge i_clock);
    chk(32'(o_irq), 32'h1);
    wr(`RCCS_ADDR_INTST, 32'h8, 4'h1, rs);
    repeat (2) @(posedge i_clock);
    chk(32'(o_irq), 32'h0);
    rdchk(`RCCS_ADDR_INTST, 32'h0, 32'hFFFFFFFF);
    test_done();
  end
endmodule
